// ---- rtl/frh_fault_response_handler.v ----
// per-channel fault response: status bits, alert and shutdown/retry
// How it works
// - input overvoltage follows its response byte
// - input overvoltage sets none-above and input bits
// - input overvoltage sets input status flag
// - alert asserts for unmasked faults
// - output overvoltage sets byte and vout flags
// - output overvoltage sets vout word summary
// - code 00 gives low-side clamp only
// - code 80 latches output off
// - code b8 retries without limit
// - code 4n deglitched latch off
// - code 78+n deglitched with retry
// - bad overvoltage code rejected, logic fault
// - mode 10 shuts down, then retry field
// - deglitch mode waits delay, then acts
// - delay field counts 10 us units
// - retry 000 stays off until cleared or off-on
// - retry 111 restarts every retry interval
// - fault bits hold until clear or off-on
// - ov, uv and ton response bytes paged rw default b8; input response byte unpaged rw default 80
// - retry interval starts at fault detection
// - undervoltage masked when inactive or ramping
`timescale 1ns/10ps
`default_nettype none
`include "frh_regs.vh"
module frh_fault_response_handler #(
  parameter PAGES        = 2,
  parameter RETRY_CYCLES = (`FRH_CLK_HZ / 1000) * `FRH_RETRY_MS
) (
  // clock, reset, enable
  input  wire                     sys_clk_i,
  input  wire                     rstn_i,
  input  wire                     ce_i,
  // command port from the serial bus decoder
  input  wire                     cmd_wr_i,
  input  wire                     cmd_rd_i,
  input  wire [7:0]               cmd_code_i,
  input  wire [$clog2(PAGES)-1:0] cmd_page_i,
  input  wire [7:0]               cmd_wdata_i,
  output reg  [7:0]               cmd_rdata_o,
  output reg                      comm_memory_logic_fault_o,
  input  wire                     clear_faults_i,
  // analog detectors and channel controls (asynchronous)
  input  wire                     input_supply_ov_i,
  input  wire                     vout_ov_i,
  input  wire                     vout_uv_i,
  input  wire                     ton_max_i,
  input  wire                     run_pin_i,
  input  wire                     ramping_i,
  // per-source alert masks
  input  wire [3:0]               alert_mask_i,
  // outputs
  output reg                      alert_n_o,
  output reg                      output_enable_o,
  output reg                      overvoltage_low_side_clamp_o,
  output reg  [7:0]               status_byte_o,
  output reg  [15:0]              status_word_o,
  output reg  [7:0]               status_input_o,
  output reg  [7:0]               status_vout_o
);
  localparam PW = $clog2(PAGES);
  localparam DLY_UNIT = (`FRH_CLK_HZ / 1000000) * `FRH_DLY_UNIT_NS / 1000;
  localparam TW = 24;
  // fault sources
  localparam SRC_VIN = 0;
  localparam SRC_OV  = 1;
  localparam SRC_UV  = 2;
  localparam SRC_TON = 3;
  // channel states
  localparam ST_ON    = 2'h0;
  localparam ST_DGL   = 2'h1;
  localparam ST_OFF   = 2'h2;
  localparam ST_RETRY = 2'h3;

  // response settings, paged except vin_resp_r
  reg [7:0] ov_resp_r  [0:PAGES-1];
  reg [7:0] uv_resp_r  [0:PAGES-1];
  reg [7:0] ton_resp_r [0:PAGES-1];
  reg [7:0] vin_resp_r;
  reg [PW-1:0] page_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [7:0]  act_resp_r;
  reg        run_q_r;
  integer    i;

  // validity check of an output overvoltage code
  function ov_code_ok;
    input [7:0] v;
    begin
      ov_code_ok = (v == `FRH_OVERVOLTAGE_LOW_SIDE_CLAMP) || (v == `FRH_OV_LATCH) ||
                   (v == `FRH_OV_RETRY) || (v[7:3] == `FRH_OV_DGL_LATCH) ||
                   (v[7:3] == `FRH_OV_DGL_RETRY);
    end
  endfunction

  // deglitch delay in clock cycles from a response byte
  function [TW-1:0] dly_cycles;
    input [7:0] v;
    begin
      dly_cycles = v[`FRH_DLY_HI:`FRH_DLY_LO] * DLY_UNIT[TW-1:0];
    end
  endfunction

  // synchronise the pins before any logic reads them
  wire [5:0] pins_s;
  frh_sync #(.W(6)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .d_i       ({ramping_i, run_pin_i, ton_max_i, vout_uv_i, vout_ov_i,
                 input_supply_ov_i}),
    .q_o       (pins_s)
  );
  wire vin_ov_s = pins_s[0];
  wire ov_s     = pins_s[1];
  wire uv_raw_s = pins_s[2];
  wire ton_s    = pins_s[3];
  wire run_s    = pins_s[4];
  wire ramp_s   = pins_s[5];
  wire run_rise = run_s && !run_q_r;
  wire run_fall = !run_s && run_q_r;
  // undervoltage only counts on an active, settled channel
  wire uv_s     = uv_raw_s && run_s && !ramp_s && output_enable_o;

  wire [7:0] ov_cur  = ov_resp_r[page_r];
  wire [7:0] uv_cur  = uv_resp_r[page_r];
  wire [7:0] ton_cur = ton_resp_r[page_r];

  // first fault that leaves normal running picks the response byte
  reg        hit;
  reg [7:0]  hit_resp;
  reg        hit_fault;
  always @* begin
    hit       = 1'b0;
    hit_resp  = 8'h00;
    hit_fault = 1'b0;
    if (vin_ov_s && vin_resp_r[`FRH_MODE_HI:`FRH_MODE_LO] != 2'h0) begin
      hit = 1'b1; hit_resp = vin_resp_r; hit_fault = vin_ov_s;
    end else if (ov_s && ov_cur != `FRH_OVERVOLTAGE_LOW_SIDE_CLAMP) begin
      hit = 1'b1; hit_resp = ov_cur; hit_fault = ov_s;
    end else if (uv_s && uv_cur[`FRH_MODE_HI:`FRH_MODE_LO] != 2'h0) begin
      hit = 1'b1; hit_resp = uv_cur; hit_fault = uv_s;
    end else if (ton_s && ton_cur[`FRH_MODE_HI:`FRH_MODE_LO] != 2'h0) begin
      hit = 1'b1; hit_resp = ton_cur; hit_fault = ton_s;
    end
  end

  // still-present check for the active fault
  wire act_fault = (act_resp_r == vin_resp_r && vin_ov_s) ||
                   (act_resp_r == ov_cur && ov_s) ||
                   (act_resp_r == uv_cur && uv_s) ||
                   (act_resp_r == ton_cur && ton_s);

  // timers for deglitch and retry interval
  wire dgl_load = (state_r == ST_ON && hit &&
                   hit_resp[`FRH_MODE_HI:`FRH_MODE_LO] == `FRH_MODE_DEGLITCH)
                  || (state_r == ST_DGL && !act_fault);
  wire dgl_done;
  frh_timer #(.W(TW)) u_dgl (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .load_i    (dgl_load),
    .count_i   (dly_cycles(state_r == ST_ON ? hit_resp : act_resp_r)),
    .done_o    (dgl_done),
    .busy_o    ()
  );
  wire ret_load = state_r == ST_ON && hit;
  wire ret_done;
  wire ret_busy;
  frh_timer #(.W(TW)) u_ret (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .load_i    (ret_load),
    .count_i   (RETRY_CYCLES[TW-1:0]),
    .done_o    (ret_done),
    .busy_o    (ret_busy)
  );

  // shutdown and retry sequencing
  wire [2:0] act_retry = act_resp_r[`FRH_RETRY_HI:`FRH_RETRY_LO];
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ON: begin
        if (hit) begin
          if (hit_resp[`FRH_MODE_HI:`FRH_MODE_LO] == `FRH_MODE_DEGLITCH)
            state_nxt = ST_DGL;
          else
            state_nxt = ST_OFF;
        end
      end
      ST_DGL: begin
        if (!act_fault)
          state_nxt = ST_ON;
        else if (dgl_done)
          state_nxt = ST_OFF;
      end
      ST_OFF: begin
        if (act_retry == `FRH_RETRY_FOREVER)
          state_nxt = ST_RETRY;
      end
      ST_RETRY: begin
        if (ret_done || !ret_busy)
          state_nxt = ST_ON;
      end
      default: state_nxt = ST_ON;
    endcase
    // retry 000 holds off until commanded off, or until faults cleared
    if (state_r == ST_OFF && (run_fall || clear_faults_i))
      state_nxt = ST_ON;
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r    <= ST_ON;
      act_resp_r <= 8'h00;
      run_q_r    <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      run_q_r <= run_s;
      if (state_r == ST_ON && hit)
        act_resp_r <= hit_resp;
    end
  end

  // output drive; clamp tracks the overvoltage only in pull-down mode
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_enable_o              <= 1'b0;
      overvoltage_low_side_clamp_o <= 1'b0;
    end else if (ce_i) begin
      output_enable_o <= run_s && (state_nxt == ST_ON || state_nxt == ST_DGL);
      overvoltage_low_side_clamp_o <= ov_s && ov_cur == `FRH_OVERVOLTAGE_LOW_SIDE_CLAMP;
    end
  end

  // sticky status; a set on the clear cycle wins, off-on clears too
  wire clr = clear_faults_i || run_rise;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_byte_o  <= 8'h00;
      status_word_o  <= 16'h0000;
      status_input_o <= 8'h00;
      status_vout_o  <= 8'h00;
      alert_n_o      <= 1'b1;
    end else if (ce_i) begin
      if (clr) begin
        status_byte_o  <= 8'h00;
        status_word_o  <= 16'h0000;
        status_input_o <= 8'h00;
        status_vout_o  <= 8'h00;
        alert_n_o      <= 1'b1;
      end
      if (vin_ov_s) begin
        status_byte_o[`FRH_SB_NONE_ABOVE]  <= 1'b1;
        status_word_o[`FRH_SW_INPUT]       <= 1'b1;
        status_input_o[`FRH_SIN_VIN_OV]    <= 1'b1;
      end
      if (ov_s) begin
        status_byte_o[`FRH_SB_VOUT_OV]     <= 1'b1;
        status_vout_o[`FRH_SVO_VOUT_OV]    <= 1'b1;
        status_word_o[`FRH_SW_VOUT]        <= 1'b1;
      end
      if (uv_s) begin
        status_byte_o[`FRH_SB_NONE_ABOVE]  <= 1'b1;
        status_word_o[`FRH_SW_VOUT]        <= 1'b1;
        status_vout_o[`FRH_SVO_VOUT_UV]    <= 1'b1;
      end
      if (ton_s) begin
        status_byte_o[`FRH_SB_NONE_ABOVE]  <= 1'b1;
        status_word_o[`FRH_SW_VOUT]        <= 1'b1;
        status_vout_o[`FRH_SVO_TON_MAX]    <= 1'b1;
      end
      if (|({ton_s, uv_s, ov_s, vin_ov_s} & ~alert_mask_i))
        alert_n_o <= 1'b0;
    end
  end

  // response byte storage with write checking
  wire [1:0] wmode = cmd_wdata_i[`FRH_MODE_HI:`FRH_MODE_LO];
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i < PAGES; i = i + 1) begin
        ov_resp_r[i]  <= `FRH_RESP_DEFAULT;
        uv_resp_r[i]  <= `FRH_RESP_DEFAULT;
        ton_resp_r[i] <= `FRH_RESP_DEFAULT;
      end
      vin_resp_r                <= `FRH_VIN_DEFAULT;
      page_r                    <= {PW{1'b0}};
      comm_memory_logic_fault_o <= 1'b0;
      cmd_rdata_o               <= 8'h00;
    end else if (ce_i) begin
      if (clear_faults_i)
        comm_memory_logic_fault_o <= 1'b0;
      if (cmd_wr_i) begin
        page_r <= cmd_page_i;
        case (cmd_code_i)
          `FRH_OFS_OV_RESP: begin
            if (ov_code_ok(cmd_wdata_i))
              ov_resp_r[cmd_page_i] <= cmd_wdata_i;
            else
              comm_memory_logic_fault_o <= 1'b1;
          end
          `FRH_OFS_UV_RESP: begin
            if (wmode != `FRH_MODE_BAD)
              uv_resp_r[cmd_page_i] <= cmd_wdata_i;
            else
              comm_memory_logic_fault_o <= 1'b1;
          end
          `FRH_OFS_TON_RESP: begin
            if (wmode != `FRH_MODE_BAD)
              ton_resp_r[cmd_page_i] <= cmd_wdata_i;
            else
              comm_memory_logic_fault_o <= 1'b1;
          end
          `FRH_OFS_VIN_RESP: begin
            if (wmode != `FRH_MODE_BAD)
              vin_resp_r <= cmd_wdata_i;
            else
              comm_memory_logic_fault_o <= 1'b1;
          end
          default: comm_memory_logic_fault_o <= 1'b1;
        endcase
      end
      if (cmd_rd_i) begin
        case (cmd_code_i)
          `FRH_OFS_OV_RESP:  cmd_rdata_o <= ov_resp_r[cmd_page_i];
          `FRH_OFS_UV_RESP:  cmd_rdata_o <= uv_resp_r[cmd_page_i];
          `FRH_OFS_TON_RESP: cmd_rdata_o <= ton_resp_r[cmd_page_i];
          `FRH_OFS_VIN_RESP: cmd_rdata_o <= vin_resp_r;
          default:           cmd_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/frh_regs.vh ----
// register offsets, field positions, codes and timing for the fault handler
`ifndef FRH_REGS_VH
`define FRH_REGS_VH

// command codes of the response settings
`define FRH_OFS_OV_RESP      8'h41
`define FRH_OFS_UV_RESP      8'h45
`define FRH_OFS_TON_RESP     8'h63
`define FRH_OFS_VIN_RESP     8'h56

// reset values
`define FRH_RESP_DEFAULT     8'hb8
`define FRH_VIN_DEFAULT      8'h80

// response byte fields
`define FRH_MODE_HI          7
`define FRH_MODE_LO          6
`define FRH_RETRY_HI         5
`define FRH_RETRY_LO         3
`define FRH_DLY_HI           2
`define FRH_DLY_LO           0

// response modes in bits 7:6
`define FRH_MODE_IGNORE      2'h0
`define FRH_MODE_DEGLITCH    2'h1
`define FRH_MODE_SHUTDOWN    2'h2
`define FRH_MODE_BAD         2'h3

// retry field codes
`define FRH_RETRY_NONE       3'h0
`define FRH_RETRY_FOREVER    3'h7

// recognised output overvoltage codes (upper five bits of 0x4n / 0x78+n)
`define FRH_OVERVOLTAGE_LOW_SIDE_CLAMP      8'h00
`define FRH_OV_LATCH         8'h80
`define FRH_OV_RETRY         8'hb8
`define FRH_OV_DGL_LATCH     5'h08
`define FRH_OV_DGL_RETRY     5'h0f

// status bit positions
`define FRH_SB_NONE_ABOVE    0
`define FRH_SB_VOUT_OV       5
`define FRH_SW_INPUT         13
`define FRH_SW_VOUT          15
`define FRH_SIN_VIN_OV       7
`define FRH_SVO_VOUT_OV      7
`define FRH_SVO_VOUT_UV      4
`define FRH_SVO_TON_MAX      2

// timing: deglitch unit and retry interval
`define FRH_CLK_HZ           10000000
`define FRH_DLY_UNIT_NS      10000
`define FRH_RETRY_MS         120

`endif

// ---- rtl/frh_sync.v ----
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/10ps
`default_nettype none
module frh_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  // levels
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  // first stage feeds only the second
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/frh_timer.v ----
// down counter used for deglitch delay and retry interval
`timescale 1ns/10ps
`default_nettype none
module frh_timer #(
  parameter W = 24
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  // control
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  output wire         done_o,
  output wire         busy_o
);
  reg [W-1:0] cnt_r;
  reg         run_r;

  // load wins over counting so a restart begins from the full count
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_r <= count_i;
        run_r <= 1'b1;
      end else if (run_r && cnt_r != {W{1'b0}}) begin
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end else begin
        run_r <= 1'b0;
      end
    end
  end

  assign done_o = run_r && (cnt_r == {W{1'b0}});
  assign busy_o = run_r;
endmodule
`default_nettype wire

// ---- verification/frh_fault_response_handler_chk.sv ----
// checker: port-level assertions for the fault response handler
`timescale 1ns/10ps
`default_nettype none
module frh_fault_response_handler_chk #(
  parameter PAGES        = 2,
  parameter RETRY_CYCLES = 50
) (
  // clock, reset and command port
  input wire                     sys_clk_i,
  input wire                     rstn_i,
  input wire                     cmd_wr_i,
  input wire                     cmd_rd_i,
  input wire [7:0]               cmd_code_i,
  input wire [$clog2(PAGES)-1:0] cmd_page_i,
  input wire [7:0]               cmd_wdata_i,
  input wire [7:0]               cmd_rdata_o,
  input wire                     comm_memory_logic_fault_o,
  input wire                     clear_faults_i,
  // channel side
  input wire                     run_pin_i,
  input wire [3:0]               alert_mask_i,
  input wire                     alert_n_o,
  input wire                     overvoltage_low_side_clamp_o,
  input wire [7:0]               status_byte_o,
  input wire [15:0]              status_word_o,
  input wire [7:0]               status_input_o,
  input wire [7:0]               status_vout_o
);
  // single clock domain, reset disables everything
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // read data only moves when a read is taken
  property p_rd_stable;
    !cmd_rd_i |=> $stable(cmd_rdata_o);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("read data moved without a read");

  // a write of 80 to code 41 followed at once by a read of 41 returns 80
  property p_wr_rd;
    cmd_wr_i && cmd_code_i == 8'h41 && cmd_wdata_i == 8'h80
      ##1 cmd_rd_i && cmd_code_i == 8'h41 && $stable(cmd_page_i)
      |=> cmd_rdata_o == 8'h80;
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("written response byte not read back");

  // mode 11 is never accepted by the ov, uv and ton response settings
  property p_bad_mode;
    cmd_wr_i && cmd_wdata_i[7:6] == 2'h3 && (cmd_code_i == 8'h41
      || cmd_code_i == 8'h45 || cmd_code_i == 8'h63)
      |=> comm_memory_logic_fault_o;
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("unsupported mode gave no logic fault");

  // input overvoltage flag comes with its summary bits
  property p_vin_bits;
    status_input_o[7] |-> status_byte_o[0] && status_word_o[13];
  endproperty
  a_vin_bits: assert property (p_vin_bits)
    else $error("input summary bits missing");

  // output overvoltage flag comes with its summary bits
  property p_vout_bits;
    status_vout_o[7] |-> status_byte_o[5] && status_word_o[15];
  endproperty
  a_vout_bits: assert property (p_vout_bits)
    else $error("output overvoltage summary bits missing");

  // unmasked overvoltage pulls the alert line in the same cycle
  property p_ov_alert;
    $rose(status_vout_o[7]) && !alert_mask_i[1] |-> !alert_n_o;
  endproperty
  a_ov_alert: assert property (p_ov_alert)
    else $error("alert not raised on overvoltage");

  // clamp only acts during a recorded overvoltage
  property p_clamp;
    overvoltage_low_side_clamp_o |-> status_vout_o[7];
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp active without overvoltage");

  // flag drops only after a clear or an off-then-on of run
  property p_sticky;
    $fell(status_vout_o[7]) |-> $past(clear_faults_i)
      || !$past(run_pin_i, 4) || !$past(run_pin_i, 5);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overvoltage flag dropped on its own");
endmodule

bind frh_fault_response_handler frh_fault_response_handler_chk #(
  .PAGES(PAGES),
  .RETRY_CYCLES(RETRY_CYCLES)
) frh_fault_response_handler_chk_i (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cmd_wr_i(cmd_wr_i),
  .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .cmd_page_i(cmd_page_i),
  .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
  .comm_memory_logic_fault_o(comm_memory_logic_fault_o),
  .clear_faults_i(clear_faults_i), .run_pin_i(run_pin_i),
  .alert_mask_i(alert_mask_i), .alert_n_o(alert_n_o),
  .overvoltage_low_side_clamp_o(overvoltage_low_side_clamp_o),
  .status_byte_o(status_byte_o), .status_word_o(status_word_o),
  .status_input_o(status_input_o), .status_vout_o(status_vout_o)
);
`default_nettype wire

// ---- verification/frh_host_model.sv ----
// host model: single-byte commands onto the handler's command port
`timescale 1ns/10ps
`default_nettype none
module frh_host_model (
  // clock and read data
  input  wire        sys_clk_i,
  input  wire  [7:0] cmd_rdata_i,
  // command strobes and fields
  output logic       cmd_wr_o,
  output logic       cmd_rd_o,
  output logic [7:0] cmd_code_o,
  output logic       cmd_page_o,
  output logic [7:0] cmd_wdata_o,
  output logic       clear_o
);
  // idle bus; callers enter the tasks on a falling edge
  initial begin
    cmd_wr_o    = 1'b0;
    cmd_rd_o    = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_page_o  = 1'b0;
    cmd_wdata_o = 8'h00;
    clear_o     = 1'b0;
  end

  // one byte per write; data inverted afterwards so no stale byte lingers
  task write_byte(input logic [7:0] code, input logic pg,
                  input logic [7:0] data);
    cmd_code_o  <= code;
    cmd_page_o  <= pg;
    cmd_wdata_o <= data;
    cmd_wr_o    <= 1'b1;
    @(negedge sys_clk_i);
    cmd_wr_o    <= 1'b0;
    cmd_wdata_o <= ~data;
  endtask

  // read strobe for one edge, byte taken once that edge has passed;
  // an idle edge follows so a next read never re-raises the strobe at once
  task read_byte(input logic [7:0] code, input logic pg,
                 output logic [7:0] data);
    cmd_code_o <= code;
    cmd_page_o <= pg;
    cmd_rd_o   <= 1'b1;
    @(negedge sys_clk_i);
    cmd_rd_o   <= 1'b0;
    data = cmd_rdata_i;
    @(negedge sys_clk_i);
  endtask

  // clear-faults pulse
  task clear_all;
    clear_o <= 1'b1;
    @(negedge sys_clk_i);
    clear_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_fault_response_handler.sv ----
// testbench: fault handler driven through the host model
`timescale 1ns/10ps
`default_nettype none
module test_fault_response_handler;
  logic       sys_clk_i = 1'b0;
  logic       rstn_i    = 1'b0;
  logic       vin_ov    = 1'b0;
  logic       vout_ov   = 1'b0;
  logic       vout_uv   = 1'b0;
  logic       run_pin   = 1'b1;
  logic       ramping   = 1'b0;
  logic       ton_max   = 1'b0;
  logic [3:0] mask      = 4'h0;
  logic       cmd_wr, cmd_rd, cmd_page, clear, comm_memory_logic_fault, alert_n, oe, clamp;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, st_byte, st_in, st_vout, d;
  logic [15:0] st_word;
  int         num_errors   = 0;
  int         total_checks = 0;

  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  // short retry interval keeps the run brief
  frh_fault_response_handler #(
    .PAGES(2),
    .RETRY_CYCLES(50)
  ) frh_fault_response_handler_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_code_i(cmd_code),
    .cmd_page_i(cmd_page), .cmd_wdata_i(cmd_wdata), .cmd_rdata_o(cmd_rdata),
    .comm_memory_logic_fault_o(comm_memory_logic_fault), .clear_faults_i(clear),
    .input_supply_ov_i(vin_ov), .vout_ov_i(vout_ov), .vout_uv_i(vout_uv),
    .ton_max_i(ton_max), .run_pin_i(run_pin), .ramping_i(ramping),
    .alert_mask_i(mask), .alert_n_o(alert_n), .output_enable_o(oe),
    .overvoltage_low_side_clamp_o(clamp), .status_byte_o(st_byte),
    .status_word_o(st_word), .status_input_o(st_in), .status_vout_o(st_vout)
  );

  frh_host_model frh_host_model_i (
    .sys_clk_i(sys_clk_i), .cmd_rdata_i(cmd_rdata), .cmd_wr_o(cmd_wr),
    .cmd_rd_o(cmd_rd), .cmd_code_o(cmd_code), .cmd_page_o(cmd_page),
    .cmd_wdata_o(cmd_wdata), .clear_o(clear)
  );

  // waits, comparisons and verdict
  task tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask
  task rd_chk(input logic [7:0] code, input logic pg, input logic [7:0] exp);
    frh_host_model_i.read_byte(code, pg, d);
    chk_byte(d, exp);
  endtask
  task bad(input logic [7:0] code, input logic [7:0] data);
    frh_host_model_i.write_byte(code, 1'b0, data);
    tick(1);
    chk_bit(comm_memory_logic_fault, 1'b1);
    frh_host_model_i.clear_all;
    chk_bit(comm_memory_logic_fault, 1'b0);
  endtask
  task run_cycle;
    run_pin = 1'b0;
    tick(6);
    run_pin = 1'b1;
    tick(8);
  endtask
  task end_of_test;
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    end_of_test;
  end

  // main sequence, all stimulus on falling edges
  initial begin
    tick(5);
    rstn_i = 1'b1;
    tick(5);
    chk_bit(oe, 1'b1);
    for (int p = 0; p < 2; p++) begin
      rd_chk(8'h41, p[0], 8'hb8);
      rd_chk(8'h45, p[0], 8'hb8);
      rd_chk(8'h63, p[0], 8'hb8);
    end
    rd_chk(8'h56, 1'b0, 8'h80);
    bad(8'h41, 8'h81);
    bad(8'h45, 8'hc0);
    bad(8'h42, 8'h00);
    rd_chk(8'h41, 1'b0, 8'hb8);
    frh_host_model_i.write_byte(8'h41, 1'b1, 8'h00);
    rd_chk(8'h41, 1'b0, 8'hb8);
    rd_chk(8'h41, 1'b1, 8'h00);
    frh_host_model_i.write_byte(8'h41, 1'b0, 8'h80);
    rd_chk(8'h41, 1'b0, 8'h80);
    // masked input overvoltage, released by run off-then-on
    mask = 4'h1;
    vin_ov = 1'b1;
    tick(5);
    chk_bit(st_in[7], 1'b1);
    chk_bit(st_byte[0] & st_word[13], 1'b1);
    chk_bit(alert_n, 1'b1);
    chk_bit(oe, 1'b0);
    vin_ov = 1'b0;
    mask = 4'h0;
    tick(20);
    chk_bit(st_in[7], 1'b1);
    run_cycle;
    chk_bit(st_in[7], 1'b0);
    chk_bit(oe, 1'b1);
    // latched-off output overvoltage
    vout_ov = 1'b1;
    tick(5);
    chk_bit(st_vout[7] & st_byte[5], 1'b1);
    chk_bit(st_word[15], 1'b1);
    chk_bit(alert_n, 1'b0);
    chk_bit(oe, 1'b0);
    vout_ov = 1'b0;
    tick(100);
    chk_bit(oe, 1'b0);
    frh_host_model_i.clear_all;
    chk_byte(st_vout, 8'h00);
    chk_bit(alert_n, 1'b1);
    run_cycle;
    // clamp only
    frh_host_model_i.write_byte(8'h41, 1'b0, 8'h00);
    vout_ov = 1'b1;
    tick(5);
    chk_bit(clamp & oe, 1'b1);
    vout_ov = 1'b0;
    tick(5);
    chk_bit(clamp, 1'b0);
    frh_host_model_i.clear_all;
    // deglitch of three units, interrupted once
    frh_host_model_i.write_byte(8'h41, 1'b0, 8'h43);
    vout_ov = 1'b1;
    tick(200);
    vout_ov = 1'b0;
    tick(10);
    vout_ov = 1'b1;
    tick(250);
    chk_bit(oe, 1'b1);
    tick(70);
    chk_bit(oe, 1'b0);
    vout_ov = 1'b0;
    tick(100);
    chk_bit(oe, 1'b0);
    frh_host_model_i.clear_all;
    run_cycle;
    // shutdown with endless retry
    frh_host_model_i.write_byte(8'h41, 1'b0, 8'hb8);
    vout_ov = 1'b1;
    tick(5);
    chk_bit(oe, 1'b0);
    vout_ov = 1'b0;
    tick(40);
    chk_bit(oe, 1'b0);
    tick(30);
    chk_bit(oe, 1'b1);
    chk_bit(st_vout[7], 1'b1);
    frh_host_model_i.clear_all;
    // one-unit deglitch with retry: brief off, back on once the fault goes
    frh_host_model_i.write_byte(8'h41, 1'b0, 8'h79);
    vout_ov = 1'b1;
    tick(104);
    chk_bit(oe, 1'b0);
    vout_ov = 1'b0;
    tick(5);
    chk_bit(oe, 1'b1);
    frh_host_model_i.clear_all;
    // undervoltage: masked while ramping, then mode 10
    ramping = 1'b1;
    vout_uv = 1'b1;
    tick(5);
    chk_bit(st_vout[4], 1'b0);
    ramping = 1'b0;
    tick(5);
    chk_bit(st_vout[4] & ~oe, 1'b1);
    vout_uv = 1'b0;
    tick(100);
    chk_bit(oe, 1'b1);
    frh_host_model_i.clear_all;
    // masked turn-on timeout: shutdown, no alert, then retry
    ton_max = 1'b1;
    mask = 4'h8;
    tick(5);
    chk_bit(st_vout[2] & st_byte[0] & ~oe, 1'b1);
    chk_bit(alert_n, 1'b1);
    ton_max = 1'b0;
    tick(100);
    chk_bit(oe, 1'b1);
    mask = 4'h0;
    frh_host_model_i.clear_all;
    frh_host_model_i.write_byte(8'h45, 1'b0, 8'h80);
    vout_uv = 1'b1;
    tick(5);
    chk_bit(oe, 1'b0);
    vout_uv = 1'b0;
    tick(100);
    chk_bit(oe, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
